// >>> core/bcu_map.svh
`ifndef BCU_MAP_SVH
`define BCU_MAP_SVH
// Instruction field positions
`define BCU_OPC_HI 31
`define BCU_OPC_LO 26
`define BCU_FSRC_HI 25
`define BCU_FSRC_LO 21
`define BCU_SSRC_HI 20
`define BCU_SSRC_LO 16
`define BCU_OFF_HI 15
`define BCU_OFF_LO 0
// Sign bit of a register and the extension above the shifted offset
`define BCU_SIGN_BIT 63
`define BCU_OFF_EXT_BITS 46
// Primary opcodes
`define BCU_OPC_REG_IMM_CLASS 6'h01
`define BCU_OPC_NOT_EQUAL 6'h05
`define BCU_OPC_LE_ZERO 6'h06
`define BCU_OPC_NOT_EQUAL_LIKELY 6'h15
`define BCU_OPC_LE_ZERO_LIKELY 6'h16
`define BCU_OPC_GT_ZERO_LIKELY 6'h17
// Register-immediate class selectors
`define BCU_RI_LTZ 5'h00
`define BCU_RI_LTZL 5'h02
`define BCU_RI_LTZAL 5'h10
`define BCU_RI_LTZALL 5'h12
// Link register number and return offset
`define BCU_LINK_REG 5'h1F
`define BCU_LINK_OFS 64'h0000_0000_0000_0008
`define BCU_SLOT_OFS 64'h0000_0000_0000_0004
`define BCU_REACH_BYTES 64'h0000_0000_0002_0000
`endif

// >>> core/bcu_pkg.sv
package bcu_pkg;
  typedef enum logic [3:0] {
    BCU_OP_NONE = 4'b0000,
    BCU_OP_LE_ZERO = 4'b0001,
    BCU_OP_LE_ZERO_LIKELY = 4'b0010,
    BCU_OP_GT_ZERO_LIKELY = 4'b0011,
    BCU_OP_LT_ZERO = 4'b0100,
    BCU_OP_LT_ZERO_LIKELY = 4'b0101,
    BCU_OP_LT_ZERO_LINK = 4'b0110,
    BCU_OP_LT_ZERO_LINK_LIKELY = 4'b0111,
    BCU_OP_NOT_EQUAL = 4'b1000,
    BCU_OP_NOT_EQUAL_LIKELY = 4'b1001
  } bcu_op_e;
  typedef enum logic [1:0] {
    BCU_ST_IDLE = 2'b00,
    BCU_ST_SLOT = 2'b01
  } bcu_state_e;
endpackage

// >>> core/bcu_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcu_map.svh"
module bcu_decode (
  // Instruction word
  input wire logic [31:0] instr_i,
  // Decoded operation
  output var bcu_pkg::bcu_op_e op_o
);
  logic [5:0] opc;
  logic [4:0] sel;
  assign opc = instr_i[`BCU_OPC_HI:`BCU_OPC_LO];
  assign sel = instr_i[`BCU_SSRC_HI:`BCU_SSRC_LO];

  // Primary opcode first, then second field for the register-immediate class
  always_comb begin
    op_o = bcu_pkg::BCU_OP_NONE;
    if (opc == `BCU_OPC_LE_ZERO) begin
      op_o = bcu_pkg::BCU_OP_LE_ZERO;
    end else if (opc == `BCU_OPC_LE_ZERO_LIKELY) begin
      op_o = bcu_pkg::BCU_OP_LE_ZERO_LIKELY;
    end else if (opc == `BCU_OPC_GT_ZERO_LIKELY) begin
      op_o = bcu_pkg::BCU_OP_GT_ZERO_LIKELY;
    end else if (opc == `BCU_OPC_NOT_EQUAL) begin
      op_o = bcu_pkg::BCU_OP_NOT_EQUAL;
    end else if (opc == `BCU_OPC_NOT_EQUAL_LIKELY) begin
      op_o = bcu_pkg::BCU_OP_NOT_EQUAL_LIKELY;
    end else if (opc == `BCU_OPC_REG_IMM_CLASS) begin
      if (sel == `BCU_RI_LTZ) begin
        op_o = bcu_pkg::BCU_OP_LT_ZERO;
      end else if (sel == `BCU_RI_LTZL) begin
        op_o = bcu_pkg::BCU_OP_LT_ZERO_LIKELY;
      end else if (sel == `BCU_RI_LTZAL) begin
        op_o = bcu_pkg::BCU_OP_LT_ZERO_LINK;
      end else if (sel == `BCU_RI_LTZALL) begin
        op_o = bcu_pkg::BCU_OP_LT_ZERO_LINK_LIKELY;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/bcu_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcu_map.svh"
module bcu_branch_unit (
  // Clock and control
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Architecture level supports likely forms
  input wire logic likely_ok_i,
  // Branch issue
  input wire logic issue_i,
  input wire logic [31:0] instr_i,
  input wire logic [63:0] pc_i,
  input wire logic [63:0] src_a_i,
  input wire logic [63:0] src_b_i,
  // Delay slot status
  input wire logic slot_done_i,
  input wire logic slot_exc_i,
  // Results
  output logic redirect_o,
  output logic [63:0] target_o,
  output logic squash_slot_o,
  output logic link_we_o,
  output logic [4:0] link_reg_o,
  output logic [63:0] link_data_o,
  output logic resv_instr_o,
  output logic [63:0] restart_pc_o,
  output logic restart_o
);
  ////////////////////////////////////////////////////////////////////////
  bcu_pkg::bcu_op_e op;
  bcu_pkg::bcu_state_e state_q;
  logic cond;
  logic likely;
  logic link;
  logic [63:0] off_ext;
  logic [63:0] tgt_d;
  logic taken_q;
  logic [63:0] tgt_q;
  logic [63:0] br_pc_q;

  bcu_decode u_decode (
    .instr_i(instr_i),
    .op_o(op)
  );

  ////////////////////////////////////////////////////////////////////////
  // Offset becomes 18-bit signed, then extends; reach is bounded by it
  assign off_ext = {{`BCU_OFF_EXT_BITS{instr_i[`BCU_OFF_HI]}}, instr_i[`BCU_OFF_HI:`BCU_OFF_LO],
    2'b00};
  assign tgt_d = pc_i + `BCU_SLOT_OFS + off_ext;

  assign likely = (op == bcu_pkg::BCU_OP_LE_ZERO_LIKELY) || (op == bcu_pkg::BCU_OP_GT_ZERO_LIKELY) ||
    (op == bcu_pkg::BCU_OP_LT_ZERO_LIKELY) || (op == bcu_pkg::BCU_OP_LT_ZERO_LINK_LIKELY) ||
    (op == bcu_pkg::BCU_OP_NOT_EQUAL_LIKELY);
  assign link = (op == bcu_pkg::BCU_OP_LT_ZERO_LINK) || (op == bcu_pkg::BCU_OP_LT_ZERO_LINK_LIKELY);

  // Condition from register contents
  always_comb begin
    case (op)
      bcu_pkg::BCU_OP_LE_ZERO, bcu_pkg::BCU_OP_LE_ZERO_LIKELY: begin
        cond = src_a_i[`BCU_SIGN_BIT] || (src_a_i == 64'h0);
      end
      bcu_pkg::BCU_OP_GT_ZERO_LIKELY: begin
        cond = !src_a_i[`BCU_SIGN_BIT] && (src_a_i != 64'h0);
      end
      bcu_pkg::BCU_OP_LT_ZERO, bcu_pkg::BCU_OP_LT_ZERO_LIKELY,
      bcu_pkg::BCU_OP_LT_ZERO_LINK, bcu_pkg::BCU_OP_LT_ZERO_LINK_LIKELY: begin
        cond = src_a_i[`BCU_SIGN_BIT];
      end
      bcu_pkg::BCU_OP_NOT_EQUAL, bcu_pkg::BCU_OP_NOT_EQUAL_LIKELY: begin
        cond = (src_a_i != src_b_i);
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Branch state: capture in branch cycle, act on slot completion
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q <= bcu_pkg::BCU_ST_IDLE;
      taken_q <= 1'b0;
      tgt_q <= 64'h0;
      br_pc_q <= 64'h0;
    end else if (ce_i) begin
      case (state_q)
        bcu_pkg::BCU_ST_IDLE: begin
          // Unsupported likely forms never enter the slot phase
          if (issue_i && (op != bcu_pkg::BCU_OP_NONE) && !(likely && !likely_ok_i)) begin
            state_q <= bcu_pkg::BCU_ST_SLOT;
            taken_q <= cond;
            tgt_q <= tgt_d;
            br_pc_q <= pc_i;
          end
        end
        bcu_pkg::BCU_ST_SLOT: begin
          if (slot_done_i || slot_exc_i) begin
            state_q <= bcu_pkg::BCU_ST_IDLE;
          end
        end
        default: begin
          state_q <= bcu_pkg::BCU_ST_IDLE;
        end
      endcase
    end
  end

  // Redirect after the slot retires, never on a slot exception
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      redirect_o <= 1'b0;
      target_o <= 64'h0;
    end else if (ce_i) begin
      redirect_o <= (state_q == bcu_pkg::BCU_ST_SLOT) && slot_done_i && !slot_exc_i && taken_q;
      target_o <= tgt_q;
    end
  end

  // Squash the slot for a not-taken likely branch, one pulse in the cycle after the branch issues
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      squash_slot_o <= 1'b0;
    end else if (ce_i) begin
      squash_slot_o <= (state_q == bcu_pkg::BCU_ST_IDLE) && issue_i && likely && likely_ok_i && !cond;
    end
  end

  // Link write regardless of outcome; a tested source of 31 is left to software
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      link_we_o <= 1'b0;
      link_reg_o <= 5'h0;
      link_data_o <= 64'h0;
    end else if (ce_i) begin
      link_we_o <= (state_q == bcu_pkg::BCU_ST_IDLE) && issue_i && link && !(likely && !likely_ok_i);
      link_reg_o <= `BCU_LINK_REG;
      link_data_o <= pc_i + `BCU_LINK_OFS;
    end
  end

  // Reserved instruction on likely forms the level lacks
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      resv_instr_o <= 1'b0;
    end else if (ce_i) begin
      resv_instr_o <= (state_q == bcu_pkg::BCU_ST_IDLE) && issue_i && likely && !likely_ok_i;
    end
  end

  // Slot exception restarts at the branch so it is evaluated again
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      restart_o <= 1'b0;
      restart_pc_o <= 64'h0;
    end else if (ce_i) begin
      restart_o <= (state_q == bcu_pkg::BCU_ST_SLOT) && slot_exc_i;
      restart_pc_o <= br_pc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_redirect_after_slot;
    @(posedge clk_sys_i) disable iff (srst_i)
      redirect_o |-> $past(state_q) == bcu_pkg::BCU_ST_SLOT && $past(slot_done_i) && $past(taken_q);
  endproperty
  a_redirect_after_slot: assert property (p_redirect_after_slot) else $error("redirect without retired slot");

  sequence s_likely_false;
    ce_i && state_q == bcu_pkg::BCU_ST_IDLE && issue_i && likely && likely_ok_i && !cond;
  endsequence
  property p_squash;
    @(posedge clk_sys_i) disable iff (srst_i) s_likely_false |=> squash_slot_o;
  endproperty
  a_squash: assert property (p_squash) else $error("not-taken likely slot not squashed");

  property p_no_squash_taken;
    @(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && state_q == bcu_pkg::BCU_ST_IDLE && issue_i && cond) |=> !squash_slot_o;
  endproperty
  a_no_squash_taken: assert property (p_no_squash_taken) else $error("taken branch squashed slot");

  property p_link_value;
    @(posedge clk_sys_i) disable iff (srst_i)
      link_we_o |-> link_reg_o == `BCU_LINK_REG && link_data_o == $past(pc_i) + `BCU_LINK_OFS;
  endproperty
  a_link_value: assert property (p_link_value) else $error("bad link write");

  property p_target;
    @(posedge clk_sys_i) disable iff (srst_i)
      (ce_i && state_q == bcu_pkg::BCU_ST_IDLE && issue_i && op != bcu_pkg::BCU_OP_NONE && !likely)
      |=> tgt_q == $past(pc_i) + `BCU_SLOT_OFS + $past(off_ext);
  endproperty
  a_target: assert property (p_target) else $error("wrong branch target");

  property p_reach;
    @(posedge clk_sys_i) disable iff (srst_i)
      (state_q == bcu_pkg::BCU_ST_SLOT) |->
        ($signed(tgt_q - br_pc_q - `BCU_SLOT_OFS) < $signed(`BCU_REACH_BYTES)) &&
        ($signed(tgt_q - br_pc_q - `BCU_SLOT_OFS) >= -$signed(`BCU_REACH_BYTES));
  endproperty
  a_reach: assert property (p_reach) else $error("offset beyond reach");

  property p_resv;
    @(posedge clk_sys_i) disable iff (srst_i)
      resv_instr_o |-> $past(likely) && !$past(likely_ok_i) && !link_we_o;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved instruction on wrong form");

  property p_restart;
    @(posedge clk_sys_i) disable iff (srst_i)
      restart_o |-> restart_pc_o == $past(br_pc_q) && !redirect_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not at branch");

  property p_cond_le;
    @(posedge clk_sys_i) disable iff (srst_i)
      (op == bcu_pkg::BCU_OP_LE_ZERO) |-> cond == ($signed(src_a_i) <= 0);
  endproperty
  a_cond_le: assert property (p_cond_le) else $error("le-zero condition wrong");

  property p_cond_gt;
    @(posedge clk_sys_i) disable iff (srst_i)
      (op == bcu_pkg::BCU_OP_GT_ZERO_LIKELY) |-> cond == ($signed(src_a_i) > 0);
  endproperty
  a_cond_gt: assert property (p_cond_gt) else $error("gt-zero condition wrong");
endmodule
`default_nettype wire

// >>> test/test_branch_condition_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcu_map.svh"
module test_branch_condition_unit;
  localparam logic [63:0] PC0 = 64'h0000_0000_0040_1000;
  localparam logic [63:0] NEG = 64'h8000_0000_0000_0000;
  localparam logic [63:0] POS = 64'h0000_0000_0000_0005;
  localparam logic [63:0] ZRO = 64'h0000_0000_0000_0000;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic likely_ok_i = 1'b1;
  logic issue_i = 1'b0;
  logic slot_done_i = 1'b0;
  logic slot_exc_i = 1'b0;
  logic [31:0] instr_i = 32'h0000_0000;
  logic [63:0] pc_i = 64'h0;
  logic [63:0] src_a_i = 64'h0;
  logic [63:0] src_b_i = 64'h0;
  logic redirect_o, squash_slot_o, link_we_o, resv_instr_o, restart_o;
  logic [4:0] link_reg_o;
  logic [63:0] target_o, link_data_o, restart_pc_o;
  int err_total = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running core clock
  always #2.5 clk_sys_i = ~clk_sys_i;

  // Clock enable held high: freezing is outside these scenarios
  bcu_branch_unit dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1), .likely_ok_i(likely_ok_i),
    .issue_i(issue_i), .instr_i(instr_i), .pc_i(pc_i), .src_a_i(src_a_i), .src_b_i(src_b_i),
    .slot_done_i(slot_done_i), .slot_exc_i(slot_exc_i), .redirect_o(redirect_o),
    .target_o(target_o), .squash_slot_o(squash_slot_o), .link_we_o(link_we_o),
    .link_reg_o(link_reg_o), .link_data_o(link_data_o), .resv_instr_o(resv_instr_o),
    .restart_pc_o(restart_pc_o), .restart_o(restart_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare one value, counting every comparison
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One branch and its delay slot; the far side retires the slot one cycle after issue
  task automatic br(input logic [5:0] opc, input logic [4:0] sel, input logic [15:0] off,
                    input logic [63:0] a, input logic [63:0] b,
                    input logic exc, input logic tk, input logic lk, input logic ln, input logic rv);
    logic [63:0] tgt;
    logic go;
    tgt = PC0 + `BCU_SLOT_OFS + {{46{off[15]}}, off, 2'b00};
    go = tk & ~exc & ~rv;
    @(posedge clk_sys_i);
    #1;
    issue_i = 1'b1;
    instr_i = {opc, 5'h02, sel, off}; // Tested source is never register 31
    pc_i = PC0;
    src_a_i = a;
    src_b_i = b;
    @(posedge clk_sys_i);
    #1;
    issue_i = 1'b0;
    slot_done_i = ~exc & ~rv;
    slot_exc_i = exc & ~rv;
    chk({63'h0, squash_slot_o}, {63'h0, lk & ~tk & ~rv});
    chk({63'h0, resv_instr_o}, {63'h0, rv});
    chk({63'h0, link_we_o}, {63'h0, ln & ~rv});
    if (ln) begin
      chk(link_data_o, PC0 + `BCU_LINK_OFS);
      chk({59'h0, link_reg_o}, {59'h0, `BCU_LINK_REG});
    end
    chk({63'h0, redirect_o}, 64'h0);
    @(posedge clk_sys_i);
    #1;
    slot_done_i = 1'b0;
    slot_exc_i = 1'b0;
    chk({63'h0, redirect_o}, {63'h0, go});
    if (go) chk(target_o, tgt);
    chk({63'h0, restart_o}, {63'h0, exc & ~rv});
    if (exc) chk(restart_pc_o, PC0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_le_zero();
    br(`BCU_OPC_LE_ZERO, 5'h00, 16'h0010, ZRO, ZRO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_LE_ZERO, 5'h00, 16'hFFF0, NEG, ZRO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_LE_ZERO, 5'h00, 16'h0010, POS, ZRO, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_LE_ZERO_LIKELY, 5'h00, 16'h0020, POS, ZRO, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    br(`BCU_OPC_LE_ZERO_LIKELY, 5'h00, 16'h0020, ZRO, ZRO, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic t_gt_zero();
    br(`BCU_OPC_GT_ZERO_LIKELY, 5'h00, 16'h0004, POS, ZRO, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    br(`BCU_OPC_GT_ZERO_LIKELY, 5'h00, 16'h0004, ZRO, ZRO, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    br(`BCU_OPC_GT_ZERO_LIKELY, 5'h00, 16'h0004, NEG, ZRO, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask

  // Every register-immediate selector; sign both set and clear only for BCU_RI_LTZ and BCU_RI_LTZAL
  task automatic t_lt_zero();
    br(`BCU_OPC_REG_IMM_CLASS, `BCU_RI_LTZ, 16'h0008, NEG, ZRO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_REG_IMM_CLASS, `BCU_RI_LTZ, 16'h0008, ZRO, ZRO, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_REG_IMM_CLASS, `BCU_RI_LTZL, 16'h0008, POS, ZRO, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    br(`BCU_OPC_REG_IMM_CLASS, `BCU_RI_LTZAL, 16'h0008, NEG, ZRO, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    br(`BCU_OPC_REG_IMM_CLASS, `BCU_RI_LTZAL, 16'h0008, POS, ZRO, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    br(`BCU_OPC_REG_IMM_CLASS, `BCU_RI_LTZALL, 16'h0008, POS, ZRO, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
  endtask

  // Operands differing only in the top bit must still count as different
  task automatic t_not_equal();
    br(`BCU_OPC_NOT_EQUAL, 5'h03, 16'h0100, NEG, ZRO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_NOT_EQUAL, 5'h03, 16'h0100, POS, POS, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_NOT_EQUAL_LIKELY, 5'h03, 16'h0100, POS, POS, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask

  // Extreme offsets, slot exception and missing likely support
  task automatic t_edges();
    br(`BCU_OPC_NOT_EQUAL, 5'h03, 16'h8000, POS, ZRO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_NOT_EQUAL, 5'h03, 16'h7FFF, POS, ZRO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    br(`BCU_OPC_NOT_EQUAL, 5'h03, 16'h0040, POS, ZRO, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    // A non-branch opcode is ignored: no slot phase, no redirect
    br(6'h00, 5'h00, 16'h0040, POS, ZRO, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    likely_ok_i = 1'b0;
    br(`BCU_OPC_NOT_EQUAL_LIKELY, 5'h03, 16'h0040, POS, ZRO, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    br(`BCU_OPC_NOT_EQUAL, 5'h03, 16'h0040, POS, ZRO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    likely_ok_i = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test();
    $display("errors %0d of %0d checks", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    chk({63'h0, redirect_o}, 64'h0);
    chk({63'h0, squash_slot_o}, 64'h0);
    chk({63'h0, link_we_o}, 64'h0);
    t_le_zero();
    t_gt_zero();
    t_lt_zero();
    t_not_equal();
    t_edges();
    finish_test();
  end
endmodule
`default_nettype wire
